// ---- design/usp_pkg.sv ----
`default_nettype none

package usp_pkg;

    // ==========================================================
    // Register map, one aligned word each.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_RELOAD = 8'h0c;

    // Status bit positions; flags clear on a write of one.
    localparam int ST_TI_BIT = 0;
    localparam int ST_RI_BIT = 1;
    localparam int CTRL_W = 6;

    // Timer mode codes.
    localparam logic [1:0] TMODE_16 = 2'b01;
    localparam logic [1:0] TMODE_8 = 2'b10;

    // ==========================================================
    // Timing and shift register marks.
    localparam int OSC_FREQ_HZ = 100_000_000;
    localparam logic [3:0] DIV_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_A = 4'd7;
    localparam logic [3:0] SAMPLE_B = 4'd8;
    localparam logic [3:0] SAMPLE_C = 4'd9;
    localparam logic [3:0] M1_FRAME_ROLLS = 4'd10;
    localparam logic [8:0] M0_RX_INIT = 9'h1fe;
    localparam logic [8:0] M1_RX_INIT = 9'h1ff;
    localparam logic [7:0] TX_LAST_MARK = 8'h01;
    localparam logic [15:0] RELOAD_RST = 16'h0000;

    // ==========================================================
    // Types.
    typedef enum logic [4:0] {
        TXS_IDLE = 5'b00001,
        TXS_M0_WAIT = 5'b00010,
        TXS_M0_SHIFT = 5'b00100,
        TXS_M1_WAIT = 5'b01000,
        TXS_M1_SEND = 5'b10000
    } usp_tx_e;

    typedef enum logic [3:0] {
        RXS_IDLE = 4'b0001,
        RXS_M0_LOAD = 4'b0010,
        RXS_M0_SHIFT = 4'b0100,
        RXS_M1 = 4'b1000
    } usp_rx_e;

    typedef struct packed {
        logic [1:0] tmode;
        logic doubler;
        logic afe;
        logic rx_enable;
        logic mode1;
    } usp_ctrl_s;

    typedef struct packed {
        usp_tx_e state;
        logic [8:0] sr;
        logic sclk;
        logic data_on;
        logic line;
    } usp_tx_s;

    typedef struct packed {
        usp_rx_e state;
        logic [8:0] sr;
        logic sclk;
        logic [3:0] div;
        logic [1:0] votes;
    } usp_rx_s;

    localparam usp_ctrl_s CTRL_RST = '{tmode: 2'b00, doubler: 1'b0, afe: 1'b0,
                                       rx_enable: 1'b0, mode1: 1'b0};
    localparam usp_tx_s TX_RST = '{state: TXS_IDLE, sr: 9'h000, sclk: 1'b1,
                                   data_on: 1'b0, line: 1'b1};
    localparam usp_rx_s RX_RST = '{state: RXS_IDLE, sr: 9'h000, sclk: 1'b1,
                                   div: 4'h0, votes: 2'b00};

    // ==========================================================
    // Bit order reversal; bits arrive least significant first.
    function automatic logic [7:0] bit_rev(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    // Two out of three vote.
    function automatic logic maj3(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction

endpackage

`default_nettype wire

// ---- design/usp_uart.sv ----
// Function
// - Bit rate is timer overflow rate over 32, doubled when doubler set.
// - 8-bit reload: rate is factor/32 times clock over 256 minus reload byte.
// - 16-bit reload: rate is factor/32 times clock over 65536 minus reload word.
// - Shift mode: eight bits LSB first on data pin, clock pin, half clock rate.
// - Shift mode buffer write loads marker; send starts one cycle later.
// - Shift mode transmit shifts right on falling clock, final shift, done flag.
// - Shift mode receive starts with enable and clear flag; loads 111111110.
// - Shift mode receive samples on rising clock, shifts in on falling.
// - Zero reaching left end ends receive, loads buffer, sets done flag.
// - Async frame: zero start, eight data LSB first, one stop into ninth bit.
// - Async buffer write loads marker; sending starts at next divider rollover.
// - Start bit first, data one bit later, first shift a bit after that.
// - Final shift ends sending and sets done flag at tenth rollover.
// - Receiver oversamples 16x; falling edge resets divider, loads 1FFH.
// - Each bit sampled at divider states seven, eight, nine, majority wins.
// - A start bit voting one resets the receiver to edge search.
// - Frame loads only with flag clear and filter off or stop one.
// - After every frame the receiver returns to edge search.
// - Doubler bit resets to zero.
`default_nettype none

module usp_uart import usp_pkg::*; (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins.
    input wire logic port_data_pin_in,
    output logic port_data_pin_out,
    output logic port_data_pin_oe_n,
    output logic port_clock_pin
);

    // ==========================================================
    // Declarations.
    usp_ctrl_s ctrl, next_ctrl;
    usp_tx_s tx, next_tx;
    usp_rx_s rx, next_rx;
    logic [15:0] reload, next_reload;
    logic [15:0] tmr, next_tmr;
    logic [3:0] txdiv, next_txdiv;
    logic [7:0] rx_buf, next_rx_buf;
    logic [31:0] next_prdata;
    logic half, next_half, tick16, next_tick16, ovf;
    logic ti, next_ti, ri, next_ri, rb8, next_rb8;
    logic next_pready, next_pslverr, next_clk_pin, next_data_out, next_oe_n;
    logic rxd_s1, rxd_s2, rxd_s3;
    logic wr, data_wr, tx_roll, ti_set, rx_load, rx_stop, rx_fall, vote;
    logic [7:0] rx_byte;
    logic [3:0] roll_cnt;

    assign wr = psel & penable & pready & pwrite;
    assign data_wr = wr && paddr == OFS_DATA;
    assign tx_roll = tick16 && txdiv == DIV_LAST;
    // The edge detector reads the second and third stages only.
    assign rx_fall = !rxd_s2 && rxd_s3;

    // ==========================================================
    // Register file. Zero wait states: pready rises in the access cycle.
    always_comb begin
        next_ctrl = ctrl;
        next_reload = reload;
        next_ti = ti;
        next_ri = ri;
        next_rb8 = rb8;
        next_rx_buf = rx_buf;
        next_prdata = 32'h0000_0000;
        next_pready = psel && !penable;
        next_pslverr = 1'b0;
        if (psel && !penable) begin
            case (paddr)
                OFS_CTRL: next_prdata = {26'h0, ctrl};
                OFS_STATUS: next_prdata = {27'h0, rx.state != RXS_IDLE,
                                           tx.state != TXS_IDLE, rb8, ri, ti};
                OFS_DATA: next_prdata = {24'h0, rx_buf};
                OFS_RELOAD: next_prdata = {16'h0, reload};
                default: next_pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            case (paddr)
                OFS_CTRL: next_ctrl = usp_ctrl_s'(pwdata[CTRL_W-1:0]);
                OFS_RELOAD: next_reload = pwdata[15:0];
                OFS_STATUS: begin
                    if (pwdata[ST_TI_BIT]) begin
                        next_ti = 1'b0;
                    end
                    if (pwdata[ST_RI_BIT]) begin
                        next_ri = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // A hardware set in the same cycle as a clear wins.
        if (ti_set) begin
            next_ti = 1'b1;
        end
        if (rx_load) begin
            next_ri = 1'b1;
            next_rx_buf = rx_byte;
            next_rb8 = rx_stop;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
            reload <= RELOAD_RST;
            ti <= 1'b0;
            ri <= 1'b0;
            rb8 <= 1'b0;
            rx_buf <= 8'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            reload <= next_reload;
            ti <= next_ti;
            ri <= next_ri;
            rb8 <= next_rb8;
            rx_buf <= next_rx_buf;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ==========================================================
    // Baud timer, overflow halver and the free transmit divide-by-16.
    always_comb begin
        next_tmr = tmr;
        ovf = 1'b0;
        case (ctrl.tmode)
            TMODE_8: begin
                if (tmr[7:0] == 8'hff) begin
                    ovf = 1'b1;
                    next_tmr[7:0] = reload[15:8];
                end else begin
                    next_tmr[7:0] = tmr[7:0] + 8'h01;
                end
            end
            TMODE_16: begin
                if (tmr == 16'hffff) begin
                    ovf = 1'b1;
                    next_tmr = reload;
                end else begin
                    next_tmr = tmr + 16'h0001;
                end
            end
            // A stopped timer follows the reload word, so the next 16-bit start overflows on time.
            default: next_tmr = reload;
        endcase
        // Every second overflow makes a 16x tick unless doubled, so a bit is 32 overflows.
        next_half = ovf ? !half : half;
        next_tick16 = ovf && (ctrl.doubler || half);
        next_txdiv = tick16 ? txdiv + 4'h1 : txdiv;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr <= 16'h0000;
            half <= 1'b0;
            tick16 <= 1'b0;
            txdiv <= 4'h0;
        end else begin
            tmr <= next_tmr;
            half <= next_half;
            tick16 <= next_tick16;
            txdiv <= next_txdiv;
        end
    end

    // ==========================================================
    // Transmitter. A write while busy is ignored rather than corrupting the frame.
    always_comb begin
        next_tx = tx;
        ti_set = 1'b0;
        case (tx.state)
            TXS_IDLE: begin
                next_tx.line = 1'b1;
                if (data_wr) begin
                    next_tx.sr = {1'b1, pwdata[7:0]};
                    next_tx.state = ctrl.mode1 ? TXS_M1_WAIT : TXS_M0_WAIT;
                end
            end
            TXS_M0_WAIT: begin
                next_tx.sclk = 1'b0;
                next_tx.state = TXS_M0_SHIFT;
            end
            TXS_M0_SHIFT: begin
                next_tx.sclk = !tx.sclk;
                if (tx.sclk) begin
                    next_tx.sr = {1'b0, tx.sr[8:1]};
                    if (tx.sr[8:1] == TX_LAST_MARK) begin
                        next_tx.state = TXS_IDLE;
                        next_tx.sclk = 1'b1;
                        ti_set = 1'b1;
                    end
                end
            end
            TXS_M1_WAIT: begin
                if (tx_roll) begin
                    next_tx.state = TXS_M1_SEND;
                    next_tx.data_on = 1'b0;
                    next_tx.line = 1'b0;
                end
            end
            TXS_M1_SEND: begin
                if (tx_roll) begin
                    if (!tx.data_on) begin
                        next_tx.data_on = 1'b1;
                        next_tx.line = tx.sr[0];
                    end else if (tx.sr[8:1] == TX_LAST_MARK) begin
                        next_tx.sr = {1'b0, tx.sr[8:1]};
                        next_tx.line = 1'b1;
                        next_tx.data_on = 1'b0;
                        next_tx.state = TXS_IDLE;
                        ti_set = 1'b1;
                    end else begin
                        next_tx.sr = {1'b0, tx.sr[8:1]};
                        next_tx.line = tx.sr[1];
                    end
                end
            end
            default: next_tx = TX_RST;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx <= TX_RST;
        end else begin
            tx <= next_tx;
        end
    end

    // ==========================================================
    // Receiver for both modes.
    always_comb begin
        next_rx = rx;
        rx_load = 1'b0;
        rx_stop = 1'b0;
        rx_byte = 8'h00;
        vote = maj3(rx.votes[0], rx.votes[1], rxd_s2);
        case (rx.state)
            RXS_IDLE: begin
                if (ctrl.rx_enable && ctrl.mode1 && rx_fall) begin
                    next_rx.state = RXS_M1;
                    next_rx.sr = M1_RX_INIT;
                    next_rx.div = 4'h0;
                end else if (ctrl.rx_enable && !ctrl.mode1 && !ri) begin
                    next_rx.state = RXS_M0_LOAD;
                    next_rx.sr = M0_RX_INIT;
                end
            end
            RXS_M0_LOAD: begin
                next_rx.sclk = 1'b0;
                next_rx.state = RXS_M0_SHIFT;
            end
            RXS_M0_SHIFT: begin
                next_rx.sclk = !rx.sclk;
                if (!rx.sclk) begin
                    next_rx.votes[0] = rxd_s2;
                end else begin
                    next_rx.sr = {rx.sr[7:0], rx.votes[0]};
                    if (!rx.sr[7]) begin
                        rx_load = 1'b1;
                        rx_byte = bit_rev({rx.sr[6:0], rx.votes[0]});
                        next_rx.state = RXS_IDLE;
                        next_rx.sclk = 1'b1;
                    end
                end
            end
            RXS_M1: begin
                if (tick16) begin
                    next_rx.div = rx.div + 4'h1;
                    case (rx.div)
                        SAMPLE_A: next_rx.votes[0] = rxd_s2;
                        SAMPLE_B: next_rx.votes[1] = rxd_s2;
                        SAMPLE_C: begin
                            if (rx.sr == M1_RX_INIT && vote) begin
                                next_rx.state = RXS_IDLE;
                            end else if (!rx.sr[8]) begin
                                rx_stop = vote;
                                rx_byte = bit_rev(rx.sr[7:0]);
                                rx_load = !ri && (!ctrl.afe || vote);
                                next_rx.state = RXS_IDLE;
                            end else begin
                                next_rx.sr = {rx.sr[7:0], vote};
                            end
                        end
                        default: ;
                    endcase
                end
            end
            default: next_rx = RX_RST;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx <= RX_RST;
        end else begin
            rx <= next_rx;
        end
    end

    // ==========================================================
    // Pins. The data pin is synchronised; all outputs are registered.
    always_comb begin
        if (tx.state == TXS_M0_SHIFT) begin
            next_clk_pin = tx.sclk;
        end else if (rx.state == RXS_M0_SHIFT) begin
            next_clk_pin = rx.sclk;
        end else begin
            next_clk_pin = tx.line;
        end
        next_data_out = tx.sr[0];
        next_oe_n = tx.state != TXS_M0_SHIFT;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            rxd_s3 <= 1'b1;
            port_clock_pin <= 1'b1;
            port_data_pin_out <= 1'b1;
            port_data_pin_oe_n <= 1'b1;
        end else begin
            rxd_s1 <= port_data_pin_in;
            rxd_s2 <= rxd_s1;
            rxd_s3 <= rxd_s2;
            port_clock_pin <= next_clk_pin;
            port_data_pin_out <= next_data_out;
            port_data_pin_oe_n <= next_oe_n;
        end
    end

    // ==========================================================
    // Checks. Rollovers since an async write, read only by the checks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            roll_cnt <= 4'h0;
        end else if (data_wr && tx.state == TXS_IDLE) begin
            roll_cnt <= 4'h0;
        end else if (tx_roll && tx.state != TXS_IDLE) begin
            roll_cnt <= roll_cnt + 4'h1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_tick_half;
        (ovf && !ctrl.doubler && !half) |=> !tick16 && half;
    endproperty
    a_tick_half: assert property (p_tick_half)
        else $error("Undoubled overflow made a tick on the first half.");

    property p_reload8;
        (ctrl.tmode == TMODE_8 && tmr[7:0] == 8'hff) |=> tmr[7:0] == $past(reload[15:8]);
    endproperty
    a_reload8: assert property (p_reload8)
        else $error("Eight-bit timer did not reload the high byte.");

    property p_reload16;
        (ctrl.tmode == TMODE_16 && tmr == 16'hffff) |=> tmr == $past(reload);
    endproperty
    a_reload16: assert property (p_reload16)
        else $error("Sixteen-bit timer did not reload the word.");

    property p_m0_send;
        (data_wr && tx.state == TXS_IDLE && !ctrl.mode1)
            |=> tx.state == TXS_M0_WAIT ##1 tx.state == TXS_M0_SHIFT ##1 !port_data_pin_oe_n;
    endproperty
    a_m0_send: assert property (p_m0_send)
        else $error("Shift mode send did not start one cycle after the write.");

    property p_m0_done;
        (tx.state == TXS_M0_SHIFT && tx.sclk && tx.sr[8:1] == TX_LAST_MARK)
            |=> tx.state == TXS_IDLE && ti;
    endproperty
    a_m0_done: assert property (p_m0_done)
        else $error("Shift mode transmit did not end on the marker.");

    property p_m0_rx_start;
        (rx.state == RXS_IDLE && !ctrl.mode1 && ctrl.rx_enable && !ri)
            |=> rx.state == RXS_M0_LOAD && rx.sr == M0_RX_INIT ##1 rx.state == RXS_M0_SHIFT;
    endproperty
    a_m0_rx_start: assert property (p_m0_rx_start)
        else $error("Shift mode receive did not load and activate in order.");

    property p_m1_start;
        (tx.state == TXS_M1_WAIT && tx_roll) |=> ##1 !port_clock_pin;
    endproperty
    a_m1_start: assert property (p_m1_start)
        else $error("Start bit not driven after the rollover.");

    property p_ti_tenth;
        (ti_set && ctrl.mode1) |-> roll_cnt == M1_FRAME_ROLLS - 4'd1;
    endproperty
    a_ti_tenth: assert property (p_ti_tenth)
        else $error("Async transmit done flag not at the tenth rollover.");

    property p_rx_fall;
        (rx.state == RXS_IDLE && ctrl.mode1 && ctrl.rx_enable && rx_fall)
            |=> rx.state == RXS_M1 && rx.sr == M1_RX_INIT && rx.div == 4'h0;
    endproperty
    a_rx_fall: assert property (p_rx_fall)
        else $error("Falling edge did not reset the receive divider.");

    property p_false_start;
        (rx.state == RXS_M1 && tick16 && rx.div == SAMPLE_C && rx.sr == M1_RX_INIT && vote)
            |=> rx.state == RXS_IDLE && $stable(ri);
    endproperty
    a_false_start: assert property (p_false_start)
        else $error("False start bit was not rejected.");

    property p_ri_guard;
        ri |=> $stable(rx_buf) && $stable(rb8);
    endproperty
    a_ri_guard: assert property (p_ri_guard)
        else $error("Receive buffer changed while the done flag was set.");

    property p_idle_high;
        (tx.state == TXS_IDLE && ctrl.mode1 && rx.state != RXS_M0_SHIFT) |=> port_clock_pin;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("Transmit line not high while idle.");

    c_m0_tx: cover property (tx.state == TXS_M0_SHIFT ##1 tx.state == TXS_IDLE);
    c_m1_rx: cover property (rx.state == RXS_M1 && rx_load);
    c_false: cover property (rx.state == RXS_M1 ##1 rx.state == RXS_IDLE && !ri);
    c_m1_tx: cover property (ti_set && ctrl.mode1);

endmodule

`default_nettype wire

// ---- testbench/usp_peer.sv ----
`default_nettype none

// ==========================================================
// Serial peer: shift peripheral in shift mode, remote async port otherwise.
module usp_peer (
    // Device pins.
    input wire logic pclk,
    input wire logic data_out,
    input wire logic oe_n,
    input wire logic clk_pin,
    // Line towards the device.
    output logic rx_line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got;

    // Takes the data pin at each rising shift clock, first bit into the low end.
    always @(posedge clk_pin) begin
        if (!oe_n) got <= {data_out, got[7:1]};
    end

    // The line has a pull-up, so it rests high outside frames.
    initial rx_line = 1'b1;

    task automatic level(input logic v);
        rx_line <= v;
    endtask

    // Sends bits low first and releases the line high at the end.
    task automatic send(input int bt, input logic [9:0] f);
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (bt) @(posedge pclk);
        end
        rx_line <= 1'b1;
    endtask

    // Catches one async frame by sampling in mid bit; bit 8 is the stop bit.
    task automatic catch(input int bt, output logic [8:0] f);
        @(negedge clk_pin);
        repeat (bt / 2) @(posedge pclk);
        for (int i = 0; i < 9; i++) begin
            repeat (bt) @(posedge pclk);
            f[i] = clk_pin;
        end
    endtask
endmodule

`default_nettype wire

// ---- testbench/usp_uart_bench.sv ----
`default_nettype none

// ==========================================================
// Bench: APB master, serial peer and a queue model of received bytes.
module usp_uart_bench import usp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'hb8e79cc1;
    logic pready, pslverr, dout, oe_n, cpin, rxl, err, ri_m, nb_m, afe_m;
    logic [8:0] fr;
    int fail_count = 0, tests_run = 0, cyc = 0, bt = 32;
    logic [7:0] q[$];
    // The data pin is shared: the device wins while its enable is low.
    wire din = oe_n ? rxl : dout;

    usp_uart DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_data_pin_in(din), .port_data_pin_out(dout),
        .port_data_pin_oe_n(oe_n), .port_clock_pin(cpin));
    usp_peer peer (.pclk(pclk), .data_out(dout), .oe_n(oe_n), .clk_pin(cpin), .rx_line(rxl));

    // Clock at 100 MHz.
    initial forever #5 pclk = ~pclk;

    function automatic logic [31:0] next_rand(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A hang counts as a mismatch and ends the run.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_flag(input int b);
        do apb(1'b0, OFS_STATUS, 32'h0); while (rd[b] !== 1'b1);
    endtask

    // Bit time follows the reload value, timer mode and doubler.
    task automatic cfg(input logic [1:0] tm, input logic dbl, input logic af,
                       input logic [15:0] r);
        afe_m = af;
        bt = 16 * (tm == TMODE_8 ? 256 - r[15:8] : 65536 - r) * (dbl ? 1 : 2);
        // Stop the timer first so that a 16-bit start restarts from the new reload value.
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_RELOAD, {16'h0, r});
        apb(1'b1, OFS_CTRL, {26'h0, tm, dbl, af, 2'b11});
    endtask

    task automatic m1_tx(input logic [7:0] b);
        fork
            peer.catch(bt, fr);
            apb(1'b1, OFS_DATA, {24'h0, b});
        join
        chk({23'h0, fr}, {23'h1, b});
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b1, OFS_STATUS, 32'h1);
        chk(cpin, 1'b1);
    endtask

    // The model loads a frame only with the flag clear and filter off or stop high.
    task automatic m1_rx(input logic [7:0] b, input logic stop, input logic clr);
        logic ld;
        ld = !ri_m && (!afe_m || stop);
        if (ld) q.push_back(b);
        if (ld) nb_m = stop;
        ri_m = ri_m | ld;
        peer.send(bt, {stop, b, 1'b0});
        repeat (bt) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[2:1], {nb_m, ri_m});
        apb(1'b0, OFS_DATA, 32'h0);
        chk(rd[7:0], q[$]);
        if (clr) apb(1'b1, OFS_STATUS, 32'h2);
        if (clr) ri_m = 1'b0;
    endtask

    initial begin
        ri_m = 1'b0;
        nb_m = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("register test done");
        apb(1'b1, OFS_DATA, 32'ha5);
        wait_flag(0);
        chk(peer.got, 8'ha5);
        apb(1'b1, OFS_STATUS, 32'h1);
        chk({oe_n, cpin}, 2'b11);
        peer.level(1'b1);
        apb(1'b1, OFS_CTRL, 32'h2);
        wait_flag(1);
        apb(1'b0, OFS_DATA, 32'h0);
        chk(rd[7:0], 8'hff);
        peer.level(1'b0);
        apb(1'b1, OFS_STATUS, 32'h2);
        wait_flag(1);
        apb(1'b0, OFS_DATA, 32'h0);
        chk(rd[7:0], 8'h00);
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_STATUS, 32'h2);
        peer.level(1'b1);
        $display("shift mode test done");
        cfg(TMODE_8, 1'b1, 1'b0, 16'hfe00);
        m1_tx(8'h96);
        m1_rx(8'h3c, 1'b1, 1'b0);
        m1_rx(8'hc3, 1'b1, 1'b1);
        peer.send(4, 10'h3fe);
        m1_rx(8'h5a, 1'b1, 1'b1);
        cfg(TMODE_16, 1'b0, 1'b1, 16'hfffe);
        m1_rx(8'h81, 1'b0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            lfsr = next_rand(lfsr);
            m1_tx(lfsr[7:0]);
            m1_rx(lfsr[15:8], 1'b1, 1'b1);
        end
        $display("async mode test done");
        close_out();
    end
endmodule

`default_nettype wire
